//--- design/dmr_pkg.sv
// constants and types for the mode register and burst order block
// Notes on behaviour
// - BA1/BA0 00 loads base, 01 extended
// - registers hold until rewritten by same command
// - base fields: A0-2 length, A3 type, A4-6 latency
// - lengths 2,4,8 coded 001,010,011 only
// - A3 zero sequential, one interleaved
// - burst wraps inside aligned block of length
// - sequential adds beat, interleaved xors beat
// - top column bit A8 x16, A7 x32
// - one length serves reads and writes
// - first read data after latency, 2.5 counted as 2
// - controller programs only when idle, waits delay
// - A7-A11 zero normal, A8 alone resets DLL
// - DLL reset followed by normal-mode register write
// - controller writes zero to unused bits
// - extended register holds DLL enable, drive strength
// - DLL enable then reset, wait 200 cycles
// - self refresh exit enables DLL automatically
// - initialization waits delay and 200 cycles
// - auto refreshes may follow first register write
// - auto-precharge bit A8 x32, A10 x16
// - no power-up value (reset here loads both with MODE_RST, 000); controller programs both
// - fixed initialization command order
package dmr_pkg;
    localparam int          ADDR_W        = 12;
    localparam logic [1:0]  BANK_BASE     = 2'h0;
    localparam logic [1:0]  BANK_EXT      = 2'h1;
    localparam int          BL_LSB        = 0;
    localparam int          BT_POS        = 3;
    localparam int          CL_LSB        = 4;
    localparam int          DLLRST_POS    = 8;
    localparam int          DLLDIS_POS    = 0;
    localparam int          DRIVE_POS     = 1;
    localparam int          TOP_COL_X16   = 8;
    localparam int          TOP_COL_X32   = 7;
    localparam int          AP_X16        = 10;
    localparam int          AP_X32        = 8;
    localparam logic [2:0]  BL_CODE_2     = 3'h1;
    localparam logic [2:0]  BL_CODE_4     = 3'h2;
    localparam logic [2:0]  BL_CODE_8     = 3'h3;
    localparam logic [2:0]  CL_CODE_2     = 3'h2;
    localparam logic [2:0]  CL_CODE_3     = 3'h3;
    localparam logic [2:0]  CL_CODE_25    = 3'h6;
    localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
    localparam int          TMRD_CYCLES   = 2;
    localparam int          DLL_CYCLES    = 200;
    localparam int          REFRESH_COUNT = 2;
    typedef enum logic [3:0] {
        CMD_NOP, CMD_PREALL, CMD_MRS, CMD_REFRESH,
        CMD_READ, CMD_WRITE, CMD_SREF_EXIT
    } dmr_cmd_type;
    typedef enum logic [1:0] {
        LAT_RSVD, LAT_2, LAT_25, LAT_3
    } dmr_lat_type;
endpackage

//--- design/dmr_if.sv
// command bus between controller and memory mode logic
`timescale 1ns/1ps
`default_nettype none
interface dmr_if;
    dmr_pkg::dmr_cmd_type         cmd;
    logic [1:0]                   ba;
    logic [dmr_pkg::ADDR_W-1:0]   addr;
    logic                         busy;
    modport ctrl (output cmd, output ba, output addr, input busy);
    modport mem  (input cmd, input ba, input addr, output busy);
endinterface
`default_nettype wire

//--- design/dmr_order.sv
// column order generator for one burst beat
`timescale 1ns/1ps
`default_nettype none
module dmr_order (
    input  wire logic [2:0] start_col,
    input  wire logic [2:0] beat,
    input  wire logic [2:0] bl_code,
    input  wire logic       interleave,
    output logic      [2:0] col
);
    logic [2:0] mask;
    logic [2:0] low;
    always_comb begin
        case (bl_code)
            dmr_pkg::BL_CODE_2: mask = 3'h1;
            dmr_pkg::BL_CODE_4: mask = 3'h3;
            default:            mask = 3'h7;
        endcase
        // wrap inside the block
        if (interleave) begin
            low = start_col ^ beat;
        end else begin
            low = 3'(start_col + beat);
        end
        col = (start_col & ~mask) | (low & mask);
    end
endmodule
`default_nettype wire

//--- design/dmr_mem.sv
// memory end: mode registers and burst column sequencing
`timescale 1ns/1ps
`default_nettype none
module dmr_mem #(
    parameter bit WIDE32 = 1'b0
) (
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    dmr_if.mem                              bus,
    output logic [dmr_pkg::ADDR_W-1:0]      base_mode_register,
    output logic [dmr_pkg::ADDR_W-1:0]      extended_mode_register,
    output logic                            dll_enabled,
    output logic                            dll_reset_pulse,
    output logic                            output_drive_strength,
    output logic [1:0]                      latency,
    output logic [8:0]                      col_addr,
    output logic                            col_valid,
    output logic                            col_write,
    output logic                            auto_precharge_bit,
    output logic                            read_data_start
);
    localparam int TOP = WIDE32 ? dmr_pkg::TOP_COL_X32 : dmr_pkg::TOP_COL_X16;
    localparam int APB = WIDE32 ? dmr_pkg::AP_X32 : dmr_pkg::AP_X16;

    logic [dmr_pkg::ADDR_W-1:0] base_ff, ext_ff;
    logic       sref_en_ff, dllrst_ff, busy_ff, ap_ff, wr_ff, val_ff;
    logic [8:0] start_ff, col_ff;
    logic [2:0] beat_ff, left_ff;
    logic       col_val_ff, col_wr_ff, col_ap_ff;
    logic       rd_pend_ff, rdstart_ff;
    logic [2:0] order_col;
    logic [2:0] nxt_len;
    logic       is_mrs;

    assign is_mrs = bus.cmd == dmr_pkg::CMD_MRS;

    // --------------------------------
    // mode registers
    // --------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            base_ff <= dmr_pkg::MODE_RST;
            ext_ff  <= dmr_pkg::MODE_RST;
        end else if (is_mrs && bus.ba == dmr_pkg::BANK_BASE) begin
            base_ff <= bus.addr;
        end else if (is_mrs && bus.ba == dmr_pkg::BANK_EXT) begin
            ext_ff <= bus.addr;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dllrst_ff <= 1'b0;
        end else begin
            // A8 alone among A7-A11 resets the DLL
            dllrst_ff <= is_mrs && bus.ba == dmr_pkg::BANK_BASE
                         && bus.addr[11:7] == 5'h02;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sref_en_ff <= 1'b0;
        end else if (bus.cmd == dmr_pkg::CMD_SREF_EXIT) begin
            sref_en_ff <= 1'b1;
        end else if (is_mrs && bus.ba == dmr_pkg::BANK_EXT) begin
            sref_en_ff <= 1'b0;
        end
    end

    // --------------------------------
    // burst sequencing
    // --------------------------------
    always_comb begin
        case (base_ff[dmr_pkg::BL_LSB +: 3])
            dmr_pkg::BL_CODE_2: nxt_len = 3'h1;
            dmr_pkg::BL_CODE_4: nxt_len = 3'h3;
            default:            nxt_len = 3'h7;
        endcase
    end

    dmr_order u_order (
        .start_col  (start_ff[2:0]),
        .beat       (beat_ff),
        .bl_code    (base_ff[dmr_pkg::BL_LSB +: 3]),
        .interleave (base_ff[dmr_pkg::BT_POS]),
        .col        (order_col)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            start_ff <= 9'h000;
            beat_ff  <= 3'h0;
            left_ff  <= 3'h0;
            val_ff   <= 1'b0;
            wr_ff    <= 1'b0;
            ap_ff    <= 1'b0;
            busy_ff  <= 1'b0;
        end else if (bus.cmd == dmr_pkg::CMD_READ || bus.cmd == dmr_pkg::CMD_WRITE) begin
            start_ff <= 9'(bus.addr[TOP:0]);
            beat_ff  <= 3'h0;
            left_ff  <= nxt_len;
            val_ff   <= 1'b1;
            wr_ff    <= bus.cmd == dmr_pkg::CMD_WRITE;
            ap_ff    <= bus.addr[APB];
            busy_ff  <= 1'b1;
        end else if (val_ff && left_ff != 3'h0) begin
            beat_ff <= 3'(beat_ff + 3'h1);
            left_ff <= 3'(left_ff - 3'h1);
        end else begin
            val_ff  <= 1'b0;
            busy_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            col_ff     <= 9'h000;
            col_val_ff <= 1'b0;
            col_wr_ff  <= 1'b0;
            col_ap_ff  <= 1'b0;
        end else begin
            // qualifiers ride with the column they belong to
            col_ff     <= {start_ff[8:3], order_col};
            col_val_ff <= val_ff;
            col_wr_ff  <= wr_ff;
            col_ap_ff  <= ap_ff;
        end
    end

    // --------------------------------
    // read latency
    // --------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_pend_ff <= 1'b0;
            rdstart_ff <= 1'b0;
        end else if (bus.cmd == dmr_pkg::CMD_READ) begin
            // latency 3 waits one extra clock
            rd_pend_ff <= latency == dmr_pkg::LAT_3;
            rdstart_ff <= latency != dmr_pkg::LAT_3;
        end else begin
            rdstart_ff <= rd_pend_ff;
            rd_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            latency <= dmr_pkg::LAT_RSVD;
        end else begin
            case (base_ff[dmr_pkg::CL_LSB +: 3])
                dmr_pkg::CL_CODE_2:  latency <= dmr_pkg::LAT_2;
                dmr_pkg::CL_CODE_3:  latency <= dmr_pkg::LAT_3;
                dmr_pkg::CL_CODE_25: latency <= dmr_pkg::LAT_25;
                default:             latency <= dmr_pkg::LAT_RSVD;
            endcase
        end
    end

    // --------------------------------
    // outputs
    // --------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            base_mode_register     <= dmr_pkg::MODE_RST;
            extended_mode_register <= dmr_pkg::MODE_RST;
            dll_enabled            <= 1'b0;
            dll_reset_pulse        <= 1'b0;
            output_drive_strength  <= 1'b0;
            col_addr               <= 9'h000;
            col_valid              <= 1'b0;
            col_write              <= 1'b0;
            auto_precharge_bit     <= 1'b0;
            read_data_start        <= 1'b0;
        end else begin
            base_mode_register     <= base_ff;
            extended_mode_register <= ext_ff;
            dll_enabled            <= sref_en_ff | ~ext_ff[dmr_pkg::DLLDIS_POS];
            dll_reset_pulse        <= dllrst_ff;
            output_drive_strength  <= ext_ff[dmr_pkg::DRIVE_POS];
            col_addr               <= col_ff;
            col_valid              <= col_val_ff;
            col_write              <= col_wr_ff;
            auto_precharge_bit     <= col_ap_ff;
            read_data_start        <= rdstart_ff;
        end
    end

    assign bus.busy = busy_ff;
endmodule
`default_nettype wire

//--- design/dmr_ctrl.sv
// controller end: initialization sequence and access issue
`timescale 1ns/1ps
`default_nettype none
module dmr_ctrl (
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    dmr_if.ctrl                             bus,
    input  wire logic [dmr_pkg::ADDR_W-1:0] mode_value,
    input  wire logic [dmr_pkg::ADDR_W-1:0] ext_value,
    input  wire logic                       req,
    input  wire logic                       req_write,
    input  wire logic [dmr_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [1:0]                 req_bank,
    output logic                            ready,
    output logic                            req_taken
);
    typedef enum logic [3:0] {
        S_PRE1, S_EMRS, S_MRS1, S_PRE2, S_REF, S_MRS2, S_WAIT, S_IDLE
    } dmr_state_type;
    dmr_state_type st_ff;
    logic [7:0] cnt_ff;
    logic [1:0] ref_ff;
    logic       wait_done;

    assign wait_done = cnt_ff == 8'h00;

    // --------------------------------
    // initialization sequencer
    // --------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_ff     <= S_PRE1;
            cnt_ff    <= 8'(dmr_pkg::DLL_CYCLES);
            ref_ff    <= 2'h0;
            bus.cmd   <= dmr_pkg::CMD_NOP;
            bus.ba    <= 2'h0;
            bus.addr  <= dmr_pkg::MODE_RST;
            ready     <= 1'b0;
            req_taken <= 1'b0;
        end else begin
            bus.cmd   <= dmr_pkg::CMD_NOP;
            req_taken <= 1'b0;
            if (!wait_done) cnt_ff <= 8'(cnt_ff - 8'h01);
            case (st_ff)
                S_PRE1: if (wait_done) begin
                    bus.cmd <= dmr_pkg::CMD_PREALL;
                    cnt_ff  <= 8'(dmr_pkg::TMRD_CYCLES);
                    st_ff   <= S_EMRS;
                end
                S_EMRS: if (wait_done) begin
                    bus.cmd  <= dmr_pkg::CMD_MRS;
                    bus.ba   <= dmr_pkg::BANK_EXT;
                    bus.addr <= ext_value & 12'h003;
                    cnt_ff   <= 8'(dmr_pkg::TMRD_CYCLES);
                    st_ff    <= S_MRS1;
                end
                S_MRS1: if (wait_done) begin
                    bus.cmd  <= dmr_pkg::CMD_MRS;
                    bus.ba   <= dmr_pkg::BANK_BASE;
                    bus.addr <= (mode_value & 12'h07F) | 12'h100;
                    cnt_ff   <= 8'(dmr_pkg::DLL_CYCLES);
                    st_ff    <= S_PRE2;
                end
                S_PRE2: if (cnt_ff <= 8'(dmr_pkg::DLL_CYCLES - dmr_pkg::TMRD_CYCLES)) begin
                    bus.cmd <= dmr_pkg::CMD_PREALL;
                    st_ff   <= S_REF;
                end
                S_REF: begin
                    bus.cmd <= dmr_pkg::CMD_REFRESH;
                    ref_ff  <= 2'(ref_ff + 2'h1);
                    if (ref_ff == 2'(dmr_pkg::REFRESH_COUNT - 1)) st_ff <= S_MRS2;
                end
                S_MRS2: begin
                    bus.cmd  <= dmr_pkg::CMD_MRS;
                    bus.ba   <= dmr_pkg::BANK_BASE;
                    bus.addr <= mode_value & 12'h07F;
                    st_ff    <= S_WAIT;
                end
                S_WAIT: if (wait_done) begin
                    st_ff <= S_IDLE;
                    ready <= 1'b1;
                end
                // busy lags the issued command by one clock
                default: if (req && !bus.busy && !req_taken) begin
                    bus.cmd   <= req_write ? dmr_pkg::CMD_WRITE : dmr_pkg::CMD_READ;
                    bus.ba    <= req_bank;
                    bus.addr  <= req_addr;
                    req_taken <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- testbench/dmr_bus_asserts.sv
// concurrent checks on the command bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module dmr_bus_asserts (
    input wire logic                       mclk,
    input wire logic                       rstn,
    input wire dmr_pkg::dmr_cmd_type       cmd,
    input wire logic [1:0]                 ba,
    input wire logic [dmr_pkg::ADDR_W-1:0] addr,
    input wire logic                       busy
);
    logic [8:0] since_rst_ff;
    logic       ext_seen_ff;
    logic [1:0] ref_cnt_ff;
    logic       mrs_base;
    logic       mrs_ext;
    logic       access;
    assign mrs_base = (cmd == dmr_pkg::CMD_MRS) && (ba == dmr_pkg::BANK_BASE);
    assign mrs_ext  = (cmd == dmr_pkg::CMD_MRS) && (ba == dmr_pkg::BANK_EXT);
    assign access   = (cmd == dmr_pkg::CMD_READ) || (cmd == dmr_pkg::CMD_WRITE);
    // --------------------------------
    // cycles since reset, init history
    // --------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) since_rst_ff <= 9'h000;
        else if (since_rst_ff != 9'h1FF) since_rst_ff <= since_rst_ff + 9'h001;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) ext_seen_ff <= 1'b0;
        else if (mrs_ext) ext_seen_ff <= 1'b1;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) ref_cnt_ff <= 2'h0;
        else if (cmd == dmr_pkg::CMD_REFRESH && ref_cnt_ff != 2'h3) ref_cnt_ff <= ref_cnt_ff + 2'h1;
    end
    // --------------------------------
    // properties
    // --------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_dll_rst;
        mrs_base && addr[dmr_pkg::DLLRST_POS];
    endsequence
    sequence s_normal_mrs;
        mrs_base && !addr[dmr_pkg::DLLRST_POS];
    endsequence
    a_dll_reset_followed: assert property (s_dll_rst |-> ##[1:1000] s_normal_mrs)
        else $error("dll reset write not followed by normal write");
    a_dll_enable_reset: assert property (mrs_ext && !addr[0] |-> ##[1:1000] s_dll_rst)
        else $error("dll enable not followed by dll reset");
    a_init_quiet: assert property (since_rst_ff < 9'h0C7 |-> cmd == dmr_pkg::CMD_NOP)
        else $error("command before start-up wait");
    a_mrd_gap: assert property (cmd == dmr_pkg::CMD_MRS |=> cmd == dmr_pkg::CMD_NOP)
        else $error("command right after register write");
    a_idle_program: assert property (busy |-> !(cmd inside {dmr_pkg::CMD_MRS,
        dmr_pkg::CMD_PREALL, dmr_pkg::CMD_REFRESH}))
        else $error("register write or precharge during burst");
    a_bank_select: assert property (cmd == dmr_pkg::CMD_MRS |-> ba inside {2'h0, 2'h1})
        else $error("register write to reserved bank code");
    a_op_bits_zero: assert property (mrs_base |-> addr[11:9] == 3'h0 && !addr[7])
        else $error("reserved operating mode bits set");
    a_legal_codes: assert property (mrs_base |-> addr[2:0] inside {3'h1, 3'h2, 3'h3}
        && addr[6:4] inside {3'h2, 3'h3, 3'h6})
        else $error("reserved length or latency code");
    a_init_order: assert property (mrs_base |-> ext_seen_ff
        && (addr[dmr_pkg::DLLRST_POS] || ref_cnt_ff >= 2'h2))
        else $error("initialization order broken");
    a_burst_busy: assert property (access |=> busy [*2])
        else $error("busy not raised for burst");
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench joining the controller and memory ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                       mclk;
    logic                       rstn;
    logic [dmr_pkg::ADDR_W-1:0] mode_value;
    logic [dmr_pkg::ADDR_W-1:0] ext_value;
    logic                       req;
    logic                       req_write;
    logic [dmr_pkg::ADDR_W-1:0] req_addr;
    logic [1:0]                 req_bank;
    logic                       ready;
    logic                       req_taken;
    logic [11:0]                base_q;
    logic [11:0]                ext_q;
    logic                       dll_en;
    logic                       dll_rst;
    logic                       drive;
    logic [1:0]                 latency;
    logic [8:0]                 col_addr;
    logic                       col_valid;
    logic                       col_write;
    logic                       ap_bit;
    logic                       rds;
    logic [8:0]                 col32;
    logic                       ap32;
    logic                       sr_dll_en;
    logic [10:0]                beats [$];
    logic [8:0]                 beats32 [$];
    int                         cyc = 0;
    int                         fail_count = 0;
    int                         compares = 0;
    int                         t_cmd, t_rds, t_col, dll_pulses, c;
    logic [11:0] cfg_mode [3] = '{12'h022, 12'h03B, 12'h061};
    logic [11:0] cfg_ext [3]  = '{12'h000, 12'h002, 12'h001};
    logic [11:0] cfg_lat [3]  = '{12'h001, 12'h003, 12'h002};
    int          cfg_len [3]  = '{4, 8, 2};
    int          cfg_rds [3]  = '{2, 3, 2};
    logic        cfg_il [3]   = '{1'b0, 1'b1, 1'b0};
    dmr_if bus();
    dmr_if bus32();
    dmr_if bus_sr();
    dmr_ctrl dmr_ctrl_i (.mclk(mclk), .rstn(rstn), .bus(bus), .mode_value(mode_value),
        .ext_value(ext_value), .req(req), .req_write(req_write), .req_addr(req_addr),
        .req_bank(req_bank), .ready(ready), .req_taken(req_taken));
    dmr_mem #(.WIDE32(1'b0)) dmr_mem_i (.mclk(mclk), .rstn(rstn), .bus(bus),
        .base_mode_register(base_q), .extended_mode_register(ext_q), .dll_enabled(dll_en),
        .dll_reset_pulse(dll_rst), .output_drive_strength(drive), .latency(latency),
        .col_addr(col_addr), .col_valid(col_valid), .col_write(col_write),
        .auto_precharge_bit(ap_bit), .read_data_start(rds));
    dmr_ctrl dmr_ctrl_x32_i (.mclk(mclk), .rstn(rstn), .bus(bus32), .mode_value(mode_value),
        .ext_value(ext_value), .req(req), .req_write(req_write), .req_addr(req_addr),
        .req_bank(req_bank), .ready(), .req_taken());
    dmr_mem #(.WIDE32(1'b1)) dmr_mem_x32_i (.mclk(mclk), .rstn(rstn), .bus(bus32),
        .base_mode_register(), .extended_mode_register(), .dll_enabled(),
        .dll_reset_pulse(), .output_drive_strength(), .latency(), .col_addr(col32),
        .col_valid(), .col_write(), .auto_precharge_bit(ap32), .read_data_start());
    dmr_mem #(.WIDE32(1'b0)) dmr_mem_sr_i (.mclk(mclk), .rstn(rstn), .bus(bus_sr),
        .base_mode_register(), .extended_mode_register(), .dll_enabled(sr_dll_en),
        .dll_reset_pulse(), .output_drive_strength(), .latency(), .col_addr(),
        .col_valid(), .col_write(), .auto_precharge_bit(), .read_data_start());
    dmr_bus_asserts dmr_bus_asserts_i (.mclk(mclk), .rstn(rstn), .cmd(bus.cmd),
        .ba(bus.ba), .addr(bus.addr), .busy(bus.busy));
    // --------------------------------
    // clock, timeout, beat capture
    // --------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (bus.cmd == dmr_pkg::CMD_READ || bus.cmd == dmr_pkg::CMD_WRITE) t_cmd = cyc;
        if (rds === 1'b1) t_rds = cyc;
        if (dll_rst === 1'b1) dll_pulses++;
        if (col_valid === 1'b1) begin
            if (beats.size() == 0) t_col = cyc;
            beats.push_back({ap_bit, col_write, col_addr});
            beats32.push_back({ap32, col32[7:0]});
        end
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // --------------------------------
    // tasks
    // --------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [8:0] exp_col(input logic [8:0] s, input int i, input int len,
                                            input logic il);
        logic [8:0] m;
        m = 9'(len - 1);
        return il ? (((s ^ 9'(i)) & m) | (s & ~m)) : (((s + 9'(i)) & m) | (s & ~m));
    endfunction
    task automatic init_run(input logic [11:0] mv, input logic [11:0] ev);
        int n;
        rstn <= 1'b0;
        mode_value <= mv;
        ext_value <= ev;
        repeat (12) @(posedge mclk);
        dll_pulses = 0;
        rstn <= 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic burst(input logic [11:0] a, input logic wr, input int len, input logic il,
                         input int lat);
        int n;
        logic [8:0] e32;
        beats.delete();
        beats32.delete();
        req <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_bank <= 2'h2;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (req_taken !== 1'b1 && n < 100);
        req <= 1'b0;
        n = 0;
        while (beats.size() < len && n < 50) begin
            @(posedge mclk);
            n++;
        end
        repeat (3) @(posedge mclk);
        chk(12'(beats.size()), 12'(len));
        for (int k = 0; k < len; k++) begin
            e32 = exp_col({1'b0, a[7:0]}, k, len, il);
            chk({1'b0, beats[k]}, {1'b0, a[10], wr, exp_col(a[8:0], k, len, il)});
            chk({3'h0, beats32[k]}, {3'h0, a[8], e32[7:0]});
        end
        chk(12'(t_col - t_cmd), 12'h003);
        if (!wr) chk(12'(t_rds - t_cmd), 12'(lat));
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        rstn = 1'b0;
        mode_value = 12'h000;
        ext_value = 12'h000;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 12'h000;
        req_bank = 2'h0;
        bus_sr.cmd = dmr_pkg::CMD_NOP;
        bus_sr.ba = dmr_pkg::BANK_EXT;
        bus_sr.addr = 12'h001;
        @(posedge mclk);
        for (c = 0; c < 3; c++) begin
            init_run(cfg_mode[c], cfg_ext[c]);
            chk({11'h0, ready}, 12'h001);
            chk(base_q, cfg_mode[c]);
            chk(ext_q, cfg_ext[c]);
            chk({10'h0, latency}, cfg_lat[c]);
            chk({10'h0, dll_en, drive}, {10'h0, ~cfg_ext[c][0], cfg_ext[c][1]});
            chk(12'(dll_pulses), 12'h001);
            burst(12'h5F5, 1'b0, cfg_len[c], cfg_il[c], cfg_rds[c]);
            burst(12'h0F5, 1'b1, cfg_len[c], cfg_il[c], cfg_rds[c]);
            burst(12'h4F6, 1'b0, cfg_len[c], cfg_il[c], cfg_rds[c]);
            chk(base_q, cfg_mode[c]);
            chk(ext_q, cfg_ext[c]);
            $display("test %0d done", c);
        end
        bus_sr.cmd <= dmr_pkg::CMD_MRS;
        @(posedge mclk);
        bus_sr.cmd <= dmr_pkg::CMD_NOP;
        repeat (3) @(posedge mclk);
        chk({11'h0, sr_dll_en}, 12'h000);
        bus_sr.cmd <= dmr_pkg::CMD_SREF_EXIT;
        @(posedge mclk);
        bus_sr.cmd <= dmr_pkg::CMD_NOP;
        repeat (3) @(posedge mclk);
        chk({11'h0, sr_dll_en}, 12'h001);
        $display("test 3 done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
